// *** core/bwlc_pkg.sv ***
/*
 * Constants and carrier types for the board watchdog and LED control.
 * Assumes a 100 MHz board clock and 32-bit APB register access.
 */
package bwlc_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL_LOW  = 8'h00;
    localparam logic [7:0] OFS_CTRL_HIGH = 8'h04;
    localparam logic [7:0] OFS_TRIGGER   = 8'h08;
    localparam logic [7:0] OFS_STATUS    = 8'h0c;
    // board_control_low fields
    localparam int LOW_SWFAIL_BIT  = 0;
    localparam int LOW_PERIOD_LSB  = 1;
    localparam int LOW_RSTDIS_BIT  = 3;
    localparam int LOW_PBDIS_BIT   = 4;
    localparam logic [4:0] LOW_RESET = 5'h00;
    // board_control_high fields
    localparam int HIGH_GREEN_BIT  = 0;
    localparam logic [0:0] HIGH_RESET = 1'h0;
    // Status fields
    localparam int ST_ARMED_BIT    = 0;
    localparam int ST_SLEEP_LSB    = 1;
    localparam int ST_OVR_BIT      = 3;
    localparam int ST_HANDLE_BIT   = 4;
    localparam int ST_BOOT_BIT     = 5;
    // Watchdog periods in seconds
    localparam logic [7:0] WD_SEL0_S = 8'h02;
    localparam logic [7:0] WD_SEL1_S = 8'h0a;
    localparam logic [7:0] WD_SEL2_S = 8'h32;
    localparam logic [7:0] WD_SEL3_S = 8'hff;
    // Timing
    localparam int CLK_MHZ         = 100;
    localparam int TICK_TIME_MS    = 1000;
    localparam int BLINK_TIME_MS   = 250;
    localparam int TICK_CYCLES     = TICK_TIME_MS * 1000 * CLK_MHZ;
    localparam int BLINK_CYCLES    = BLINK_TIME_MS * 1000 * CLK_MHZ;
    localparam int HANDLE_TIME_S   = 4;
    // One extra tick because the shared tick phase is unknown
    localparam logic [2:0] HANDLE_TICKS = 3'(HANDLE_TIME_S + 1);
    // Sleep state codes
    localparam logic [1:0] SLP_S0 = 2'h0;
    localparam logic [1:0] SLP_S3 = 2'h1;
    localparam logic [1:0] SLP_S4 = 2'h2;
    localparam logic [1:0] SLP_S5 = 2'h3;

    typedef struct packed {
        logic red;
        logic green;
    } bwlc_led_t;

    typedef struct packed {
        bwlc_led_t power_good_led;
        bwlc_led_t general_purpose_led;
        bwlc_led_t disk_activity_led;
    } bwlc_leds_t;

    typedef enum {
        PS_INIT,
        PS_ON,
        PS_OVR_OPEN,
        PS_OFF_CLOSED,
        PS_OFF_UNLOCKED
    } bwlc_pstate_t;
endpackage

// *** core/bwlc_top.sv ***
/*
 * Board watchdog, front-panel LED driver and handle/reset logic,
 * with an APB register slave.
 * Assumes all pin inputs are asynchronous to clk; reset is the system
 * reset, so a watchdog expiry ends up clearing this block itself.
 */
`timescale 1ns/1ns
`default_nettype none

module bwlc_top
    import bwlc_pkg::*;
#(
    parameter int TICK_CYC  = TICK_CYCLES,
    parameter int BLINK_CYC = BLINK_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        handle_open,
    input  wire logic        handle_button,
    input  wire logic        reset_button_n,
    input  wire logic        backplane_push_reset_n,
    input  wire logic        chipset_pin_red_led,
    input  wire logic [1:0]  chipset_sleep,
    input  wire logic        rails_ok,
    input  wire logic        power_fault,
    input  wire logic        sata1_activity,
    input  wire logic        sata2_activity,
    output logic             system_reset_req,
    output logic             power_button_pulse,
    output logic             soft_off_req,
    output bwlc_leds_t       leds
);
    localparam int NPIN = 11;

    logic [NPIN-1:0]  pin_meta_reg;
    logic [NPIN-1:0]  pin_sync_reg;
    logic             h_open;
    logic             h_btn;
    logic             rbtn_n;
    logic             bp_n;
    logic             red_pin;
    logic [1:0]       slp_in;
    logic             ok_pin;
    logic             fault_pin;
    logic             act1;
    logic             act2;
    logic [4:0]       ctrl_low_reg;
    logic [0:0]       ctrl_high_reg;
    logic             boot_reg;
    logic [31:0]      prdata_reg;
    logic             wr_en;
    logic             trig_wr;
    logic             mapped;
    logic [31:0]      tick_cnt_reg;
    logic             tick;
    logic [31:0]      blink_cnt_reg;
    logic             blink_reg;
    logic             wd_armed_reg;
    logic [7:0]       wd_sec_reg;
    logic             wd_expired_reg;
    logic [7:0]       wd_period;
    logic             hbtn_prev_reg;
    logic             pb_pulse_reg;
    logic [2:0]       h_cnt_reg;
    bwlc_pstate_t     ps_reg;
    bwlc_pstate_t     ps_next;
    logic [1:0]       slp;
    bwlc_leds_t       leds_next;
    bwlc_leds_t       leds_reg;

    function automatic logic [7:0] period_secs(input logic [1:0] sel);
        case (sel)
            2'h0:    period_secs = WD_SEL0_S;
            2'h1:    period_secs = WD_SEL1_S;
            2'h2:    period_secs = WD_SEL2_S;
            default: period_secs = WD_SEL3_S;
        endcase
    endfunction

    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // Two-flop synchronisers for every pin input
    // No reset: pins are sampled during reset, so start-up sees the real
    // handle, and idle-high reset lines never fake a reset request
    always_ff @(posedge clk) begin
        pin_meta_reg <= {handle_open, handle_button, reset_button_n,
                         backplane_push_reset_n, chipset_pin_red_led,
                         chipset_sleep, rails_ok, power_fault,
                         sata1_activity, sata2_activity};
        pin_sync_reg <= pin_meta_reg;
    end

    assign {h_open, h_btn, rbtn_n, bp_n, red_pin, slp_in, ok_pin,
            fault_pin, act1, act2} = pin_sync_reg;

    // APB slave: zero wait states, error on unmapped offsets
    assign mapped = hit(paddr, OFS_CTRL_LOW) | hit(paddr, OFS_CTRL_HIGH)
                  | hit(paddr, OFS_TRIGGER) | hit(paddr, OFS_STATUS);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign wr_en   = psel & penable & pwrite;
    assign trig_wr = wr_en & hit(paddr, OFS_TRIGGER);
    assign prdata  = prdata_reg;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl_low_reg  <= LOW_RESET;
            ctrl_high_reg <= HIGH_RESET;
        end else if (wr_en && hit(paddr, OFS_CTRL_LOW)) begin
            ctrl_low_reg <= pwdata[4:0];
        end else if (wr_en && hit(paddr, OFS_CTRL_HIGH)) begin
            ctrl_high_reg <= pwdata[0:0];
        end
    end

    // Boot indication lasts until software first writes anything
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            boot_reg <= 1'b1;
        end else if (wr_en) begin
            boot_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prdata_reg <= '0;
        end else if (psel && !penable && !pwrite) begin
            prdata_reg <= '0;
            if (hit(paddr, OFS_CTRL_LOW)) begin
                prdata_reg[4:0] <= ctrl_low_reg;
            end
            if (hit(paddr, OFS_CTRL_HIGH)) begin
                prdata_reg[0:0] <= ctrl_high_reg;
            end
            if (hit(paddr, OFS_STATUS)) begin
                prdata_reg[ST_ARMED_BIT]  <= wd_armed_reg;
                prdata_reg[ST_SLEEP_LSB +: 2] <= slp;
                prdata_reg[ST_OVR_BIT]    <= (ps_reg != PS_ON);
                prdata_reg[ST_HANDLE_BIT] <= h_open;
                prdata_reg[ST_BOOT_BIT]   <= boot_reg;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tick_cnt_reg <= '0;
        end else if (tick) begin
            tick_cnt_reg <= '0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h1;
        end
    end
    assign tick = (tick_cnt_reg == 32'(TICK_CYC - 1));

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            blink_cnt_reg <= '0;
            blink_reg     <= 1'b0;
        end else if (blink_cnt_reg == 32'(BLINK_CYC - 1)) begin
            blink_cnt_reg <= '0;
            blink_reg     <= ~blink_reg;
        end else begin
            blink_cnt_reg <= blink_cnt_reg + 32'h1;
        end
    end

    assign wd_period = period_secs(ctrl_low_reg[LOW_PERIOD_LSB +: 2]);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wd_armed_reg <= 1'b0;
        end else if (trig_wr) begin
            wd_armed_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wd_sec_reg     <= '0;
            wd_expired_reg <= 1'b0;
        end else if (trig_wr) begin
            wd_sec_reg <= '0;
        end else if (wd_armed_reg && tick) begin
            if (wd_sec_reg >= wd_period) begin
                wd_expired_reg <= 1'b1;
            end else begin
                wd_sec_reg <= wd_sec_reg + 8'h1;
            end
        end
    end

    // Button may be disabled, backplane not
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            system_reset_req <= 1'b0;
        end else begin
            system_reset_req <= wd_expired_reg | ~bp_n
                              | (~rbtn_n & ~ctrl_low_reg[LOW_RSTDIS_BIT]);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hbtn_prev_reg <= 1'b0;
            pb_pulse_reg  <= 1'b0;
        end else begin
            hbtn_prev_reg <= h_btn;
            pb_pulse_reg  <= h_btn & ~hbtn_prev_reg
                           & ~ctrl_low_reg[LOW_PBDIS_BIT];
        end
    end
    assign power_button_pulse = pb_pulse_reg;

    // Seconds the handle has been open, saturating
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            h_cnt_reg <= '0;
        end else if (!h_open) begin
            h_cnt_reg <= '0;
        end else if (tick && h_cnt_reg != HANDLE_TICKS) begin
            h_cnt_reg <= h_cnt_reg + 3'h1;
        end
    end

    always_comb begin
        ps_next = ps_reg;
        case (ps_reg)
            PS_INIT: begin
                ps_next = h_open ? PS_OVR_OPEN : PS_ON;
            end
            PS_ON: begin
                if (h_cnt_reg == HANDLE_TICKS
                    && !ctrl_low_reg[LOW_PBDIS_BIT]) begin
                    ps_next = PS_OVR_OPEN;
                end
            end
            PS_OVR_OPEN: begin
                if (!h_open) begin
                    ps_next = PS_OFF_CLOSED;
                end
            end
            PS_OFF_CLOSED: begin
                if (h_open) begin
                    ps_next = PS_OFF_UNLOCKED;
                end
            end
            PS_OFF_UNLOCKED: begin
                if (!h_open) begin
                    ps_next = PS_ON;
                end
            end
            default: ps_next = PS_INIT;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ps_reg <= PS_INIT;
        end else begin
            ps_reg <= ps_next;
        end
    end

    assign soft_off_req = (ps_reg != PS_ON) && (ps_reg != PS_INIT);
    assign slp = soft_off_req ? SLP_S5 : slp_in;

    always_comb begin
        leds_next = '0;
        // Steady green needs rails and reset released
        // Open handle still blinks in S5
        if (slp != SLP_S0 && !h_open) begin
            leds_next.power_good_led = '0;
        end else if (fault_pin) begin
            leds_next.power_good_led.red = 1'b1;
        end else if (h_open) begin
            leds_next.power_good_led = {blink_reg, blink_reg};
        end else if (ok_pin && !system_reset_req) begin
            leds_next.power_good_led.green = 1'b1;
        end
        if (ctrl_low_reg[LOW_SWFAIL_BIT]) begin
            leds_next.power_good_led = {blink_reg, 1'b0};
        end
        case (slp)
            SLP_S5: begin
                leds_next.general_purpose_led.green = 1'b1;
                leds_next.disk_activity_led.green   = 1'b1;
            end
            SLP_S4: leds_next.general_purpose_led.green = 1'b1;
            SLP_S3: leds_next.disk_activity_led.green   = 1'b1;
            default: begin
                leds_next.general_purpose_led.red =
                    boot_reg ? blink_reg : red_pin;
                leds_next.general_purpose_led.green =
                    ~boot_reg & ctrl_high_reg[HIGH_GREEN_BIT];
                leds_next.disk_activity_led.red =
                    act2 & blink_reg;
                leds_next.disk_activity_led.green =
                    (act1 | act2) & blink_reg;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            leds_reg <= '0;
        end else begin
            leds_reg <= leds_next;
        end
    end
    assign leds = leds_reg;

    sequence trig_s;
        trig_wr;
    endsequence

    sequence restarted_s;
        wd_sec_reg == 8'h00;
    endsequence

    idle_never_a: assert property (@(posedge clk) disable iff (reset)
        !wd_armed_reg |-> !wd_expired_reg)
        else $error("watchdog expired while idle");

    arm_first_a: assert property (@(posedge clk) disable iff (reset)
        trig_s |=> wd_armed_reg)
        else $error("trigger did not arm watchdog");

    stay_armed_a: assert property (@(posedge clk) disable iff (reset)
        wd_armed_reg |=> wd_armed_reg)
        else $error("watchdog disarmed");

    count_restart_a: assert property (@(posedge clk)
        disable iff (reset) trig_s |=> restarted_s)
        else $error("trigger did not restart count");

    expire_a: assert property (@(posedge clk) disable iff (reset)
        wd_armed_reg && tick && !trig_wr && wd_sec_reg >= wd_period
        |=> wd_expired_reg ##1 system_reset_req)
        else $error("overrun did not reset board");

    sw_fail_a: assert property (@(posedge clk) disable iff (reset)
        ctrl_low_reg[LOW_SWFAIL_BIT] |=>
        leds.power_good_led == {$past(blink_reg), 1'b0})
        else $error("power LED not blinking red");

    bp_reset_a: assert property (@(posedge clk) disable iff (reset)
        !bp_n |=> system_reset_req)
        else $error("backplane line did not reset");

    pulse_one_a: assert property (@(posedge clk) disable iff (reset)
        power_button_pulse |=> !power_button_pulse)
        else $error("power button pulse too long");

    override_a: assert property (@(posedge clk) disable iff (reset)
        ps_reg == PS_ON && h_cnt_reg == HANDLE_TICKS
        && !ctrl_low_reg[LOW_PBDIS_BIT] |=> soft_off_req)
        else $error("handle override missed");

    resume_a: assert property (@(posedge clk) disable iff (reset)
        ps_reg == PS_OFF_UNLOCKED && !h_open |=> !soft_off_req)
        else $error("relock did not resume");
endmodule

`default_nettype wire

// *** sim/testbench.sv ***
/*
 * Self-checking bench for bwlc_top: APB tasks plus pin scenarios.
 * Assumes shortened tick and blink counts; no far-side model is used.
 */
`timescale 1ns/1ns
`default_nettype none
module testbench
    import bwlc_pkg::*;
;
    localparam int TK = 20;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        handle_open = 1'b0;
    logic        handle_button = 1'b0;
    logic        reset_button_n = 1'b1;
    logic        backplane_push_reset_n = 1'b1;
    logic        chipset_pin_red_led = 1'b0;
    logic [1:0]  chipset_sleep = 2'h0;
    logic        rails_ok = 1'b1;
    logic        power_fault = 1'b0;
    logic        sata1_activity = 1'b0;
    logic        sata2_activity = 1'b0;
    logic        system_reset_req;
    logic        power_button_pulse;
    logic        soft_off_req;
    bwlc_leds_t  leds;
    int          n_errors = 0;
    int          total_checks = 0;
    int          pc;
    logic [5:0]  hi;
    logic [5:0]  lo;
    logic [31:0] q;
    logic        e;
    logic [5:0]  tbl [1:3] = '{6'h01, 6'h04, 6'h05};
    int          per [4] = '{2, 10, 50, 255};

    bwlc_top #(
        .TICK_CYC  (TK),
        .BLINK_CYC (4)
    ) dut (
        .clk                    (clk),
        .reset                  (reset),
        .psel                   (psel),
        .penable                (penable),
        .pwrite                 (pwrite),
        .paddr                  (paddr),
        .pwdata                 (pwdata),
        .prdata                 (prdata),
        .pready                 (pready),
        .pslverr                (pslverr),
        .handle_open            (handle_open),
        .handle_button          (handle_button),
        .reset_button_n         (reset_button_n),
        .backplane_push_reset_n (backplane_push_reset_n),
        .chipset_pin_red_led    (chipset_pin_red_led),
        .chipset_sleep          (chipset_sleep),
        .rails_ok               (rails_ok),
        .power_fault            (power_fault),
        .sata1_activity         (sata1_activity),
        .sata2_activity         (sata2_activity),
        .system_reset_req       (system_reset_req),
        .power_button_pulse     (power_button_pulse),
        .soft_off_req           (soft_off_req),
        .leds                   (leds)
    );

    always #5 clk = ~clk;

    task results;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task tmo;
        n_errors++;
        $display("MISMATCH t=%0t wait limit got=%h exp=%h", $time, 0, 1);
        results();
    endtask

    task step(input int n);
        repeat (n) @(posedge clk);
    endtask

    task smp;
        @(negedge clk);
    endtask

    // Request held until pready is seen high at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
            if (i > 50) tmo();
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        chk(e, a > OFS_STATUS);
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(q, x);
        chk(e, a > OFS_STATUS);
    endtask

    // Blinking shows as hi=1, lo=0 over the window
    task watch(input int n);
        hi = '0;
        lo = '1;
        pc = 0;
        repeat (n) begin
            @(negedge clk);
            hi = hi | leds;
            lo = lo & leds;
            pc = pc + int'(power_button_pulse);
        end
    endtask

    task wt(input logic so, input int lim, output int c);
        c = 0;
        while ((so ? soft_off_req : system_reset_req) !== 1'b1) begin
            @(negedge clk);
            c++;
            if (c > lim) tmo();
        end
    endtask

    task rst(input logic h);
        @(posedge clk);
        reset <= 1'b1;
        handle_open <= h;
        handle_button <= 1'b0;
        reset_button_n <= 1'b1;
        backplane_push_reset_n <= 1'b1;
        chipset_pin_red_led <= 1'b0;
        chipset_sleep <= SLP_S0;
        rails_ok <= 1'b1;
        power_fault <= 1'b0;
        sata1_activity <= 1'b0;
        sata2_activity <= 1'b0;
        step(20);
        reset <= 1'b0;
    endtask

    initial begin
        int c;
        rst(1'b0);
        step(8);
        watch(20);
        chk({hi[5:2], lo[5:2]}, 8'h64);
        rdc(OFS_CTRL_LOW, 32'h0);
        rdc(OFS_CTRL_HIGH, 32'h0);
        rdc(8'h10, 32'h0);
        step(15 * TK);
        smp();
        chk(system_reset_req, 1'b0);
        rdc(OFS_STATUS, 32'h20);
        for (int k = 0; k < 4; k++) begin
            step(1);
            chipset_pin_red_led <= k[1];
            wr(OFS_CTRL_HIGH, 32'(k & 1));
            step(5);
            smp();
            chk(leds.general_purpose_led, 32'(k));
        end
        wr(8'h10, 32'h0);
        rdc(OFS_CTRL_HIGH, 32'h1);
        wr(OFS_CTRL_LOW, 32'h1);
        step(4);
        watch(20);
        chk({hi[5:4], lo[5:4]}, 4'h8);
        wr(OFS_CTRL_LOW, 32'h0);
        step(4);
        watch(12);
        chk({hi[5:4], lo[5:4]}, 4'h5);
        step(1);
        power_fault <= 1'b1;
        step(5);
        watch(12);
        chk({hi[5:4], lo[5:4]}, 4'ha);
        step(1);
        power_fault <= 1'b0;
        rails_ok <= 1'b0;
        step(5);
        watch(12);
        chk(hi[4], 1'b0);
        step(1);
        rails_ok <= 1'b1;
        sata1_activity <= 1'b1;
        step(5);
        watch(20);
        chk({hi[1:0], lo[1:0]}, 4'h4);
        step(1);
        sata1_activity <= 1'b0;
        sata2_activity <= 1'b1;
        step(5);
        watch(20);
        chk({hi[1:0], lo[1:0]}, 4'hc);
        step(1);
        sata2_activity <= 1'b0;
        for (int s = 1; s < 4; s++) begin
            step(1);
            chipset_sleep <= 2'(s);
            step(5);
            watch(12);
            chk({hi, lo}, {tbl[s], tbl[s]});
        end
        step(1);
        chipset_sleep <= SLP_S0;
        handle_button <= 1'b1;
        watch(10);
        chk(pc, 1);
        step(1);
        handle_button <= 1'b0;
        wr(OFS_CTRL_LOW, 32'h10);
        handle_button <= 1'b1;
        watch(10);
        chk(pc, 0);
        step(1);
        handle_button <= 1'b0;
        wr(OFS_CTRL_LOW, 32'h0);
        handle_open <= 1'b1;
        watch(20);
        chk({hi[5:4], lo[5:4]}, 4'hc);
        wt(1'b1, 6 * TK, c);
        chk(32'(c + 20 >= 4 * TK), 32'h1);
        step(1);
        handle_open <= 1'b0;
        step(6);
        smp();
        chk(soft_off_req, 1'b1);
        step(1);
        handle_open <= 1'b1;
        step(6);
        handle_open <= 1'b0;
        step(6);
        smp();
        chk(soft_off_req, 1'b0);
        rst(1'b1);
        step(6);
        watch(20);
        chk({soft_off_req, hi[5:4], lo[5:4]}, 5'h1c);
        rst(1'b0);
        backplane_push_reset_n <= 1'b0;
        step(8);
        smp();
        chk({system_reset_req, leds[4]}, 2'h2);
        rst(1'b0);
        reset_button_n <= 1'b0;
        step(8);
        smp();
        chk(system_reset_req, 1'b1);
        rst(1'b0);
        wr(OFS_CTRL_LOW, 32'h8);
        reset_button_n <= 1'b0;
        step(10);
        smp();
        chk(system_reset_req, 1'b0);
        step(1);
        backplane_push_reset_n <= 1'b0;
        step(6);
        smp();
        chk(system_reset_req, 1'b1);
        for (int s = 0; s < 4; s++) begin
            rst(1'b0);
            wr(OFS_CTRL_LOW, 32'(s << 1));
            wr(OFS_TRIGGER, 32'h0);
            rdc(OFS_STATUS, 32'h1);
            for (int k = 0; k < 2; k++) begin
                step(per[s] * TK - 20);
                smp();
                chk(system_reset_req, 1'b0);
                wr(OFS_TRIGGER, 32'h0);
            end
            wr(OFS_CTRL_LOW, 32'(s << 1));
            rdc(OFS_STATUS, 32'h1);
            wt(1'b0, (per[s] + 2) * TK, c);
            chk(32'(c >= per[s] * TK - 10), 32'h1);
        end
        rst(1'b0);
        wr(OFS_CTRL_LOW, 32'h6);
        wr(OFS_TRIGGER, 32'h0);
        step(5 * TK);
        smp();
        chk(system_reset_req, 1'b0);
        wr(OFS_CTRL_LOW, 32'h0);
        wt(1'b0, 3 * TK, c);
        chk(32'(c <= TK + 5), 32'h1);
        results();
    end
endmodule
`default_nettype wire
